// [core/crb_map.svh]
`ifndef CRB_MAP_SVH
`define CRB_MAP_SVH
// register byte offsets
`define CRB_OFS_HEADER      8'h18
`define CRB_OFS_BUSNAME     8'h1C
`define CRB_OFS_OPTIONS     8'h20
`define CRB_OFS_LINKCTL     8'h24
// header fields
`define CRB_HDR_CHECK_LSB   0
`define CRB_HDR_CHECK_W     16
// bus name constant
`define CRB_BUSNAME_VAL     32'h31333934
// bus-options reset and fixed-bit mask
`define CRB_OPT_RESET       32'h0000A002
`define CRB_OPT_FIXED_MASK  32'h07000F3F
`define CRB_OPT_MAXREC_LSB  12
`define CRB_MAXREC_2048     4'hA
// remote rom quadlet addresses (low 12 bits of bus address)
`define CRB_ROM_HEADER      12'h400
`define CRB_ROM_BUSNAME     12'h404
`define CRB_ROM_OPTIONS     12'h408
// link control register bit
`define CRB_LINK_ON_BIT     17
// axi response codes
`define CRB_RESP_OKAY       2'h0
`define CRB_RESP_SLVERR     2'h2
`endif

// [core/crb_pkg.sv]
package crb_pkg;
   // register bank state
   typedef struct packed {
      logic [31:0] header;
      logic [31:0] options;
      logic        link_on;
      logic        eep_loaded;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        awready;
      logic        wready;
      logic        arready;
      logic        rom_valid;
      logic [31:0] rom_data;
   } crb_state_t;
   // remote rom read request
   typedef struct packed {
      logic        req;
      logic [11:0] addr;
   } crb_rom_req_t;
endpackage

// [core/crb_regs.sv]
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "crb_map.svh"
// Summary of operation
// - header register is ROM quadlet at 0x400
// - reset loads check value from EEPROM
// - bus name reads constant, first info quadlet
// - bus options is second info quadlet
// - max request resets to 2048, hard reset
// - reserved option bits 26-24 read zero
module crb_regs
   import crb_pkg::*;
(
   input  wire logic        CORE_CLK,        // 50 MHz core clock
   input  wire logic        SYS_RST,         // hardware reset, sync, high
   input  wire logic        SOFT_RST,        // software reset, sync, high
   input  wire logic        EEP_PRESENT,     // serial eeprom attached
   input  wire logic        EEP_VALID,       // eeprom check value ready
   input  wire logic [15:0] EEP_CHECK,       // check value from eeprom
   input  wire logic        ROM_REQ,         // remote rom quadlet read
   input  wire logic [11:0] ROM_ADDR,        // rom byte address low bits
   output logic             ROM_VALID,       // rom answer strobe
   output logic [31:0]      ROM_DATA,        // rom quadlet value
   output logic             LINK_ON,         // link enabled
   input  wire logic [7:0]  S_AXI_AWADDR,    // write address
   input  wire logic        S_AXI_AWVALID,   // write address valid
   output logic             S_AXI_AWREADY,   // write address ready
   input  wire logic [31:0] S_AXI_WDATA,     // write data
   input  wire logic [3:0]  S_AXI_WSTRB,     // byte strobes
   input  wire logic        S_AXI_WVALID,    // write data valid
   output logic             S_AXI_WREADY,    // write data ready
   output logic [1:0]       S_AXI_BRESP,     // write response
   output logic             S_AXI_BVALID,    // write response valid
   input  wire logic        S_AXI_BREADY,    // write response ready
   input  wire logic [7:0]  S_AXI_ARADDR,    // read address
   input  wire logic        S_AXI_ARVALID,   // read address valid
   output logic             S_AXI_ARREADY,   // read address ready
   output logic [31:0]      S_AXI_RDATA,     // read data
   output logic [1:0]       S_AXI_RRESP,     // read response
   output logic             S_AXI_RVALID,    // read data valid
   input  wire logic        S_AXI_RREADY     // read data ready
);

   crb_state_t  s_ff;       // registered state
   crb_state_t  nxt_s;      // next state
   logic [31:0] opt_view;   // options as read back
   logic [31:0] wmask;      // strobe byte mask
   logic [31:0] hdr_next;   // header merged with the held write
   logic [31:0] opt_next;   // options merged with the held write
   logic [31:0] host_view;  // register value at the read address
   logic        host_err;   // read address hits no register
   logic [31:0] rom_view;   // quadlet value at the rom address
   logic        eep_take;   // eeprom check value lands now
   logic        aw_take;    // write address captured now
   logic        w_take;     // write data captured now
   logic        wr_fire;    // both write halves held, write now
   logic        b_done;     // host took the write response
   logic        ar_take;    // read address captured now
   logic        r_done;     // host took the read data
   logic        link_wr;    // held write covers the link enable byte

   // bus timing: a valid seen at one edge raises its ready for one
   // cycle from the next, so a master that holds valid until it sees
   // ready completes the handshake one cycle later; a write lands once
   // both halves are held, and its response stands until bready; a
   // read raises arready and rvalid together, and rvalid stands until
   // rready; a remote rom read answers one cycle after its request

   // the eeprom load flag is cleared only by a hardware reset, so a late
   // report after a software reset cannot overwrite a host-written value

   // limitation: the link enable bit is not checked against the header;
   // software must program lengths and check value before setting it

   // fixed option bits always show their default; reserved ones are zero
   // bits 26-24 are the reserved ones, the rest of the mask are fixed fields
   assign opt_view = (s_ff.options & ~`CRB_OPT_FIXED_MASK)
                   | (`CRB_OPT_RESET & `CRB_OPT_FIXED_MASK);

   // expand write strobes to a bit mask
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         wmask[i*8 +: 8] = {8{s_ff.w_strb[i]}};
      end
   end

   // merge the held write data into the old value, byte by byte; the
   // fixed option bits may take the data here, the read view hides them
   assign hdr_next = (s_ff.header & ~wmask) | (s_ff.w_data & wmask);
   assign opt_next = (s_ff.options & ~wmask) | (s_ff.w_data & wmask);

   // link enable sits in byte two of the link control word
   assign link_wr = s_ff.w_strb[2];

   // handshake and load conditions, kept apart so that the next-state
   // logic below reads as a list of events
   always_comb
   begin
      // first eeprom report after reset; later reports are ignored
      eep_take = EEP_PRESENT && EEP_VALID && !s_ff.eep_loaded;
      // write address: one at a time, none while a response stands
      aw_take  = S_AXI_AWVALID && !s_ff.aw_got && !s_ff.awready && !s_ff.bvalid;
      // write data: same gating as the address channel
      w_take   = S_AXI_WVALID && !s_ff.w_got && !s_ff.wready && !s_ff.bvalid;
      // the write itself waits for both halves
      wr_fire  = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
      // response handshake closes the write
      b_done   = s_ff.bvalid && S_AXI_BREADY;
      // read address: refused while read data still stands
      ar_take  = S_AXI_ARVALID && !s_ff.rvalid && !s_ff.arready;
      // read handshake closes the read
      r_done   = s_ff.rvalid && S_AXI_RREADY;
   end

   // host read multiplexer, sampled when the read address is taken
   always_comb
   begin
      host_view = 32'h00000000; // default, also for unmapped
      host_err  = 1'b0;         // default, mapped
      case (S_AXI_ARADDR)
         `CRB_OFS_HEADER:
         begin
            host_view = s_ff.header; // whole header, host side
         end
         `CRB_OFS_BUSNAME:
         begin
            host_view = `CRB_BUSNAME_VAL;
         end
         `CRB_OFS_OPTIONS:
         begin
            host_view = opt_view;
         end
         `CRB_OFS_LINKCTL:
         begin
            host_view = 32'(s_ff.link_on) << `CRB_LINK_ON_BIT; // enable bit alone
         end
         default:
         begin
            host_view = 32'h00000000; // unmapped reads zero
            host_err  = 1'b1;         // and answers with an error
         end
      endcase
   end

   // remote rom multiplexer: the first three quadlets of the rom
   // come from these registers, anything else reads zero here
   always_comb
   begin
      rom_view = 32'h00000000; // default for unknown quadlets
      case (ROM_ADDR)
         `CRB_ROM_HEADER:
         begin
            rom_view = s_ff.header;
         end
         `CRB_ROM_BUSNAME:
         begin
            rom_view = `CRB_BUSNAME_VAL;
         end
         `CRB_ROM_OPTIONS:
         begin
            rom_view = opt_view;
         end
         default:
         begin
            rom_view = 32'h00000000; // outside the bus info block
         end
      endcase
   end

   // next state: every change of the register bank except the hardware reset is made here
   always_comb
   begin
      // hold everything; ready and rom strobes last one cycle only
      nxt_s           = s_ff;
      nxt_s.rom_valid = 1'b0;
      nxt_s.awready   = 1'b0;
      nxt_s.wready    = 1'b0;
      nxt_s.arready   = 1'b0;
      // load check value once eeprom reports it after reset
      if (eep_take)
      begin
         nxt_s.header[`CRB_HDR_CHECK_LSB +: `CRB_HDR_CHECK_W] = EEP_CHECK;
         nxt_s.eep_loaded = 1'b1; // no second load until reset
      end
      // software reset drops the link but leaves max request alone
      if (SOFT_RST)
      begin
         nxt_s.link_on = 1'b0;
      end
      // accept write address
      if (aw_take)
      begin
         nxt_s.awready = 1'b1;         // one-cycle ready
         nxt_s.aw_got  = 1'b1;         // address held
         nxt_s.aw_addr = S_AXI_AWADDR; // byte offset
      end
      // accept write data
      if (w_take)
      begin
         nxt_s.wready = 1'b1;        // one-cycle ready
         nxt_s.w_got  = 1'b1;        // data held
         nxt_s.w_data = S_AXI_WDATA; // word
         nxt_s.w_strb = S_AXI_WSTRB; // byte lanes
      end
      // perform write once both halves are held; a host write that
      // meets the eeprom load wins, being the later of the two
      if (wr_fire)
      begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got  = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp  = `CRB_RESP_OKAY;
         case (s_ff.aw_addr)
            `CRB_OFS_HEADER:
            begin
               nxt_s.header = hdr_next; // lengths and check value
            end
            `CRB_OFS_BUSNAME:
            begin
               nxt_s.bresp = `CRB_RESP_OKAY; // read-only, write ignored
            end
            `CRB_OFS_OPTIONS:
            begin
               nxt_s.options = opt_next;
            end
            `CRB_OFS_LINKCTL:
            begin
               if (link_wr)
               begin
                  nxt_s.link_on = s_ff.w_data[`CRB_LINK_ON_BIT];
               end
            end
            default:
            begin
               nxt_s.bresp = `CRB_RESP_SLVERR; // unmapped
            end
         endcase
      end
      // write response handshake
      if (b_done)
      begin
         nxt_s.bvalid = 1'b0; // ready for the next write
      end
      // read channel: the address is looked up as it is taken, so the
      // data need no second cycle; rdata then holds until the next read
      if (ar_take)
      begin
         nxt_s.arready = 1'b1;      // one-cycle ready
         nxt_s.rvalid  = 1'b1;      // data stands from now
         nxt_s.rdata   = host_view; // value at the address
         if (host_err)
         begin
            nxt_s.rresp = `CRB_RESP_SLVERR; // unmapped
         end
         else
         begin
            nxt_s.rresp = `CRB_RESP_OKAY; // mapped
         end
      end
      else if (r_done)
      begin
         nxt_s.rvalid = 1'b0; // read closed
      end
      // remote rom quadlet reads, answered one cycle later
      if (ROM_REQ)
      begin
         nxt_s.rom_valid = 1'b1;     // one-cycle answer strobe
         nxt_s.rom_data  = rom_view;
      end
   end

   // state register with hardware reset; the bank clears and options
   // take their defaults, the software reset is handled in next state
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         s_ff         <= '0;
         s_ff.options <= `CRB_OPT_RESET;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from flops, a plain copy of state bits
   assign ROM_VALID     = s_ff.rom_valid;
   assign ROM_DATA      = s_ff.rom_data;
   assign LINK_ON       = s_ff.link_on;
   assign S_AXI_AWREADY = s_ff.awready;
   assign S_AXI_WREADY  = s_ff.wready;
   assign S_AXI_BVALID  = s_ff.bvalid;
   assign S_AXI_BRESP   = s_ff.bresp;
   assign S_AXI_ARREADY = s_ff.arready;
   assign S_AXI_RVALID  = s_ff.rvalid;
   assign S_AXI_RDATA   = s_ff.rdata;
   assign S_AXI_RRESP   = s_ff.rresp;

endmodule

// [tb/crb_regs_asserts.sv]
`timescale 1ns/100ps
module crb_regs_asserts
(
   input wire logic        CORE_CLK,      // clock
   input wire logic        SYS_RST,       // reset
   input wire logic        ROM_REQ,       // rom read
   input wire logic [11:0] ROM_ADDR,      // rom address
   input wire logic        ROM_VALID,     // rom answer
   input wire logic [31:0] ROM_DATA,      // rom quadlet
   input wire logic [7:0]  S_AXI_ARADDR,  // read address
   input wire logic        S_AXI_ARVALID, // address valid
   input wire logic        S_AXI_ARREADY, // address ready
   input wire logic [31:0] S_AXI_RDATA    // read data
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // remote reads of name and options quadlets
   sequence s_name; (ROM_REQ && ROM_ADDR == 12'h404) ##1 ROM_VALID; endsequence
   sequence s_opt; (ROM_REQ && ROM_ADDR == 12'h408) ##1 ROM_VALID; endsequence
   // host read address taken at one offset
   sequence s_ar(a); S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == a; endsequence
   chk_rom_answer: assert property (ROM_REQ |=> ROM_VALID)
      else $error("rom late");
   chk_rom_solo: assert property (ROM_VALID |-> $past(ROM_REQ))
      else $error("rom unasked");
   chk_rom_name: assert property (s_name |-> ROM_DATA == 32'h31333934)
      else $error("rom name");
   chk_host_name: assert property (s_ar(8'h1C) |-> S_AXI_RDATA == 32'h31333934)
      else $error("host name");
   chk_rom_fixed: assert property (s_opt |-> ROM_DATA[11:8] == 4'h0 && ROM_DATA[5:0] == 6'h02)
      else $error("rom fixed");
   chk_rom_rsvd: assert property (s_opt |-> ROM_DATA[26:24] == 3'h0)
      else $error("rom reserved");
   chk_host_fixed: assert property (s_ar(8'h20) |-> S_AXI_RDATA[26:24] == 3'h0 && S_AXI_RDATA[11:8] == 4'h0)
      else $error("host fixed");
endmodule
bind crb_regs crb_regs_asserts u_chk
(
   .CORE_CLK      (CORE_CLK),
   .SYS_RST       (SYS_RST),
   .ROM_REQ       (ROM_REQ),
   .ROM_ADDR      (ROM_ADDR),
   .ROM_VALID     (ROM_VALID),
   .ROM_DATA      (ROM_DATA),
   .S_AXI_ARADDR  (S_AXI_ARADDR),
   .S_AXI_ARVALID (S_AXI_ARVALID),
   .S_AXI_ARREADY (S_AXI_ARREADY),
   .S_AXI_RDATA   (S_AXI_RDATA)
);

// [tb/crb_rom_node.sv]
`timescale 1ns/100ps
module crb_rom_node
(
   input wire logic        CORE_CLK,  // clock
   output logic            ROM_REQ,   // read strobe
   output logic [11:0]     ROM_ADDR,  // quadlet address
   input wire logic        ROM_VALID, // answer strobe
   input wire logic [31:0] ROM_DATA   // answer quadlet
);
   initial
   begin
      ROM_REQ = 1'b0;
      ROM_ADDR = 12'hFFF;
   end
   // one remote quadlet read, after gap idle cycles
   task automatic fetch(input logic [11:0] a, input int gap, output logic [31:0] v);
      repeat (gap + 1) @(posedge CORE_CLK);
      ROM_REQ <= 1'b1;
      ROM_ADDR <= a;
      @(posedge CORE_CLK);
      ROM_REQ <= 1'b0;
      ROM_ADDR <= ~a; // released address shows no stale value
      do @(posedge CORE_CLK); while (ROM_VALID !== 1'b1);
      v = ROM_DATA;
   endtask
endmodule

// [tb/config_rom_bus_info_regs_bench.sv]
`timescale 1ns/100ps
`include "crb_map.svh"
module config_rom_bus_info_regs_bench
   import crb_pkg::*;
;
   logic        CORE_CLK = 0, SYS_RST = 1, SOFT_RST = 0, EEP_PRESENT = 1, EEP_VALID = 0;
   logic        ROM_REQ, ROM_VALID, LINK_ON, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
   logic [15:0] EEP_CHECK = 16'h5AC3;
   logic [11:0] ROM_ADDR;
   logic [31:0] ROM_DATA, S_AXI_RDATA, d, S_AXI_WDATA = 0;
   logic [7:0]  S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
   logic [3:0]  S_AXI_WSTRB = 4'hF;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
   int          n_errors = 0, total_checks = 0, cyc = 0;
   crb_regs u_dut (.*);
   crb_rom_node u_node (.*);
   always #10 CORE_CLK = ~CORE_CLK;
   // hang guard
   always @(posedge CORE_CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         n_errors++;
         test_done();
      end
   end
   task test_done;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, s);
      total_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task hard_reset;
      SYS_RST <= 1'b1;
      repeat (6) @(posedge CORE_CLK);
      SYS_RST <= 1'b0;
   endtask
   // host write, each channel released when taken
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CORE_CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= v;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do
      begin
         @(posedge CORE_CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end
      while (S_AXI_BVALID !== 1'b1);
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   // host read into d and r
   task rd(input logic [7:0] a);
      @(posedge CORE_CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do
      begin
         @(posedge CORE_CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end
      while (S_AXI_RVALID !== 1'b1);
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask
   // eeprom value, name writes ignored, option fixed bits
   task t_regs;
      logic [31:0] v;
      @(posedge CORE_CLK);
      EEP_VALID <= 1'b1;
      @(posedge CORE_CLK);
      EEP_VALID <= 1'b0;
      rd(`CRB_OFS_HEADER);
      chk("header", 32'h00005AC3, d);
      wr(`CRB_OFS_BUSNAME, 32'h0);
      chk("name resp", 32'h0, r);
      rd(`CRB_OFS_BUSNAME);
      chk("name", 32'h31333934, d);
      u_node.fetch(12'h404, 3, d);
      chk("rom name", 32'h31333934, d);
      rd(`CRB_OFS_OPTIONS);
      chk("opt reset", 32'h0000A002, d);
      for (int i = 0; i < 2; i++)
      begin
         v = (i == 0) ? 32'h0 : 32'hFFFFFFFF;
         wr(`CRB_OFS_OPTIONS, v);
         rd(`CRB_OFS_OPTIONS);
         chk("opt", (v & 32'hF8FFF0C0) | 32'h2, d);
         u_node.fetch(12'h408, i, d);
         chk("rom opt", (v & 32'hF8FFF0C0) | 32'h2, d);
      end
   endtask
   // link enable, soft and hard reset, unmapped read
   task t_link;
      wr(`CRB_OFS_HEADER, 32'h0410ABCD);
      wr(`CRB_OFS_LINKCTL, 32'h00020000);
      chk("link on", 32'h1, LINK_ON);
      u_node.fetch(12'h400, 0, d);
      chk("rom header", 32'h0410ABCD, d);
      @(posedge CORE_CLK);
      SOFT_RST <= 1'b1;
      @(posedge CORE_CLK);
      SOFT_RST <= 1'b0;
      rd(`CRB_OFS_OPTIONS);
      chk("opt soft", 32'hF8FFF0C2, d);
      chk("link off", 32'h0, LINK_ON);
      S_AXI_WSTRB <= 4'hB;
      wr(`CRB_OFS_LINKCTL, 32'h00020000);
      chk("link strobe", 32'h0, LINK_ON);
      S_AXI_WSTRB <= 4'hF;
      hard_reset();
      rd(`CRB_OFS_OPTIONS);
      chk("opt hard", 32'h0000A002, d);
      EEP_PRESENT <= 1'b0;
      EEP_VALID <= 1'b1;
      @(posedge CORE_CLK);
      EEP_VALID <= 1'b0;
      rd(`CRB_OFS_HEADER);
      chk("no eeprom", 32'h0, d);
      rd(8'h30);
      chk("unmapped", 32'h2, r);
   endtask
   initial
   begin
      hard_reset();
      t_regs();
      t_link();
      test_done();
   end
endmodule
